// File: hw/pbs_sram_port.sv
// top: synchronous pipelined burst memory port with byte writes and sleep
// Operation
// - enable set: write only selected lanes
// - write cycle forces data drivers off
// - controller strobe write start conditions
// - controller write one cycle, advance ignored
// - global write stores all lanes plus parity
// - two-bit wrapping counter loaded from address
// - low advance steps counter, reads and writes; not in the cycle after a processor strobe
// - interleaved order xors start value
// - linear order adds modulo four
// - sleep entry and exit take two cycles
// - pending access dropped; asleep outputs off
// - deselect conditions tri-state outputs
// - processor strobe cycle always starts read
// - controller strobe without write starts read
// - low advance continues burst, read/write; no step in the cycle after a processor strobe
// - high advance suspends, repeats current address
// - combined write qualifier from enables
// - read drives only when enabled and selected
// - any lane combination, byte plus parity
// - read data one clock after address
// - processor strobe write takes two cycles
// - both strobes low: processor strobe wins
// - first cycle after deselect stays tri-stated
module pbs_sram_port (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // address and control, active low unless noted
  input wire logic [pbs_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic I_CHIP_SELECT_PRIMARY_N,
  input wire logic I_CHIP_SELECT_ACTIVE_HIGH,
  input wire logic I_CHIP_SELECT_SECONDARY_LOW_N,
  input wire logic I_PROCESSOR_ADDRESS_STROBE_N,
  input wire logic I_CONTROLLER_ADDRESS_STROBE_N,
  input wire logic I_BURST_ADVANCE_N,
  input wire logic I_GLOBAL_WRITE_ALL_N,
  input wire logic I_BYTE_WRITE_MASTER_ENABLE_N,
  input wire logic [pbs_pkg::LANES-1:0] I_BYTE_LANE_SELECT_N,
  // asynchronous controls and strap
  input wire logic I_OUTPUT_DRIVE_ENABLE_N,
  input wire logic I_SLEEP_REQUEST,
  input wire logic I_BURST_MODE,
  // data lines, parity in the top bit of each lane
  input wire logic [pbs_pkg::DATA_W-1:0] I_DATA_LINES,
  output logic [pbs_pkg::DATA_W-1:0] O_DATA_LINES,
  output logic O_DATA_LINES_OE,
  // status
  output logic O_ASLEEP
);
  import pbs_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];

  // two-flop synchronisers on the asynchronous inputs
  logic oe_n_s1_q, oe_n_s2_q, zz_s1_q, zz_s2_q, mode_s1_q, mode_s2_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      oe_n_s1_q <= 1'b1;
      oe_n_s2_q <= 1'b1;
      zz_s1_q <= 1'b0;
      zz_s2_q <= 1'b0;
      mode_s1_q <= 1'b1;
      mode_s2_q <= 1'b1;
    end else begin
      oe_n_s1_q <= I_OUTPUT_DRIVE_ENABLE_N;
      oe_n_s2_q <= oe_n_s1_q;
      zz_s1_q <= I_SLEEP_REQUEST;
      zz_s2_q <= zz_s1_q;
      mode_s1_q <= I_BURST_MODE;
      mode_s2_q <= mode_s1_q;
    end
  end

  // combined write qualifier and lane mask
  logic wr_any, gw;
  logic [LANES-1:0] lane_we;
  assign gw = !I_GLOBAL_WRITE_ALL_N;
  assign wr_any = gw || (!I_BYTE_WRITE_MASTER_ENABLE_N
                  && !(&I_BYTE_LANE_SELECT_N));
  assign lane_we = gw ? {LANES{1'b1}}
                 : (I_BYTE_WRITE_MASTER_ENABLE_N ? {LANES{1'b0}}
                 : ~I_BYTE_LANE_SELECT_N);

  // sleep sequencing: two cycles in and two out
  pbs_state_t st_q;
  logic [1:0] slp_cnt_q;
  logic awake;
  assign awake = (st_q == PBS_IDLE) || (st_q == PBS_ACT);
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      st_q <= PBS_IDLE;
      slp_cnt_q <= 2'h0;
    end else begin
      case (st_q)
        PBS_IDLE, PBS_ACT: begin
          if (zz_s2_q) begin
            st_q <= PBS_PWR;
            slp_cnt_q <= 2'h1;
          end
        end
        PBS_PWR: begin
          if (!zz_s2_q) begin
            st_q <= PBS_IDLE;
            slp_cnt_q <= 2'h0;
          end else if (slp_cnt_q == SLEEP_CNT_MAX - 2'h1) begin
            st_q <= PBS_SLEEP;
            slp_cnt_q <= 2'h0;
          end else begin
            slp_cnt_q <= slp_cnt_q + 2'h1;
          end
        end
        PBS_SLEEP: begin
          if (!zz_s2_q) begin
            if (slp_cnt_q == SLEEP_CNT_MAX - 2'h1) begin
              st_q <= PBS_IDLE;
              slp_cnt_q <= 2'h0;
            end else begin
              slp_cnt_q <= slp_cnt_q + 2'h1;
            end
          end else begin
            slp_cnt_q <= 2'h0;
          end
        end
        default: begin
          st_q <= PBS_IDLE;
          slp_cnt_q <= 2'h0;
        end
      endcase
    end
  end

  // cycle decode; processor strobe wins over controller strobe
  logic processor_address_strobe, controller_address_strobe, sel_all, p_start, c_start, desel, cont;
  assign processor_address_strobe = !I_PROCESSOR_ADDRESS_STROBE_N;
  assign controller_address_strobe = !I_CONTROLLER_ADDRESS_STROBE_N;
  assign sel_all = !I_CHIP_SELECT_PRIMARY_N && I_CHIP_SELECT_ACTIVE_HIGH
                   && !I_CHIP_SELECT_SECONDARY_LOW_N;
  // processor strobe ignored when primary select is off
  assign p_start = awake && processor_address_strobe && sel_all;
  assign c_start = awake && !processor_address_strobe && controller_address_strobe && sel_all;
  assign desel = awake && ((I_CHIP_SELECT_PRIMARY_N && controller_address_strobe)
                 || (!I_CHIP_SELECT_PRIMARY_N && (processor_address_strobe || controller_address_strobe)
                 && !sel_all));
  assign cont = awake && !controller_address_strobe && (!processor_address_strobe || I_CHIP_SELECT_PRIMARY_N);

  // access tracking
  logic active_q, rd_q, p_first_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BURST_W-1:0] cur;
  logic do_wr, do_rd;
  assign do_wr = (c_start && wr_any)
              || (cont && active_q && wr_any);
  assign do_rd = p_start
              || (c_start && !wr_any)
              || (cont && active_q && !wr_any);

  pbs_burst_if bif ();
  assign bif.load = p_start || c_start;
  // high advance leaves the counter alone, so the address repeats
  assign bif.step = cont && active_q && !I_BURST_ADVANCE_N
                    && !p_first_q;
  assign bif.interleaved = mode_s2_q;
  assign bif.start = I_ADDR[BURST_W-1:0];
  assign cur = bif.cur;
  pbs_burst_counter u_cnt (
    .clk(I_CORE_CLK),
    .rst(I_SYS_RST),
    .bif(bif)
  );

  // address register and access flags
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      active_q <= 1'b0;
      p_first_q <= 1'b0;
      addr_q <= '0;
    end else if (!awake) begin
      active_q <= 1'b0;
      p_first_q <= 1'b0;
    end else if (p_start || c_start) begin
      addr_q <= I_ADDR;
      active_q <= 1'b1;
      p_first_q <= p_start;
    end else if (desel) begin
      active_q <= 1'b0;
      p_first_q <= 1'b0;
    end else begin
      p_first_q <= 1'b0;
    end
  end

  // memory address: upper bits held, low bits from counter
  logic [MEM_AW-1:0] wa, ra;
  assign wa = (c_start) ? I_ADDR[MEM_AW-1:0]
            : {addr_q[MEM_AW-1:BURST_W], cur};
  assign ra = p_start || c_start ? I_ADDR[MEM_AW-1:0]
            : {addr_q[MEM_AW-1:BURST_W], cur};

  // byte-lane writes; unselected lanes keep their contents
  // one process owns the array, so it has a single driver
  always_ff @(posedge I_CORE_CLK) begin
    for (int g = 0; g < LANES; g++) begin
      if (do_wr && lane_we[g]) begin
        mem[wa][g*LANE_W +: LANE_W] <= I_DATA_LINES[g*LANE_W +: LANE_W];
      end
    end
  end

  // pipelined read data and drive decision
  logic rd_pend_q, mask_q;
  logic [DATA_W-1:0] rdata_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      rd_pend_q <= 1'b0;
      mask_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      rd_pend_q <= awake && do_rd && !do_wr;
      mask_q <= !awake || (bif.load && !active_q);
      if (do_rd) begin
        rdata_q <= mem[ra];
      end
    end
  end
  assign rd_q = rd_pend_q;

  // output register and enable, off when asleep or writing
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_DATA_LINES <= '0;
      O_DATA_LINES_OE <= 1'b0;
      O_ASLEEP <= 1'b0;
    end else begin
      O_DATA_LINES <= rdata_q;
      O_DATA_LINES_OE <= rd_q && !mask_q && !oe_n_s2_q
                         && awake && !do_wr;
      O_ASLEEP <= (st_q == PBS_SLEEP);
    end
  end

  a_write_tristate: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) do_wr |=> !O_DATA_LINES_OE)
    else $error("drivers on during write");
  a_sleep_quiet: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) O_ASLEEP |-> !O_DATA_LINES_OE)
    else $error("drivers on while asleep");
  a_sleep_entry: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) awake && zz_s2_q ##1 zz_s2_q
    |=> st_q == PBS_SLEEP)
    else $error("sleep entry not two cycles");
  a_oe_gate: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) $past(oe_n_s2_q) |-> !O_DATA_LINES_OE)
    else $error("drive with enable high");
  a_desel_tristate: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) desel && !bif.load ##1 !bif.load
    |=> !O_DATA_LINES_OE)
    else $error("drive after deselect");
  a_first_masked: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) bif.load && !active_q |=> ##1
    !O_DATA_LINES_OE)
    else $error("first cycle not masked");
  a_pstrobe_read: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) p_start |-> !do_wr)
    else $error("processor strobe wrote");
  a_no_step_load: assert property (@(posedge I_CORE_CLK)
    disable iff (I_SYS_RST) c_start |-> !bif.step)
    else $error("advance honoured on load");
endmodule

// File: hw/pbs_pkg.sv
// package: constants and types for the pipelined burst memory port
package pbs_pkg;
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1024;
  localparam int MEM_AW = 10;
  localparam int BURST_W = 2;
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

  typedef enum logic [1:0] {
    PBS_IDLE = 2'b00,
    PBS_ACT = 2'b01,
    PBS_PWR = 2'b11,
    PBS_SLEEP = 2'b10
  } pbs_state_t;
endpackage

// File: hw/pbs_burst_if.sv
// interface: burst counter load and step controls
interface pbs_burst_if;
  import pbs_pkg::*;
  logic load;
  logic step;
  logic interleaved;
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] cur;
  modport ctrl (output load, output step, output interleaved,
    output start, input cur);
  modport cnt (input load, input step, input interleaved,
    input start, output cur);
endinterface

// File: hw/pbs_burst_counter.sv
// two-bit wraparound burst counter, linear or interleaved order
module pbs_burst_counter (
  input wire logic clk,
  input wire logic rst,
  pbs_burst_if.cnt bif
);
  import pbs_pkg::*;

  logic [BURST_W-1:0] start_q;
  logic [BURST_W-1:0] off_q;

  // offset counts 0..3; interleave xors it, linear adds it
  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= BURST_ZERO;
      off_q <= BURST_ZERO;
    end else if (bif.load) begin
      start_q <= bif.start;
      off_q <= BURST_ZERO;
    end else if (bif.step) begin
      off_q <= off_q + BURST_ONE;
    end
  end

  assign bif.cur = bif.interleaved ? (start_q ^ off_q)
                                   : (start_q + off_q);

  a_interleave_order: assert property (@(posedge clk) disable iff (rst)
    bif.interleaved && bif.step && !bif.load
    |=> (bif.cur ^ start_q) == $past(bif.cur ^ start_q) + BURST_ONE)
    else $error("interleave step wrong");
  a_linear_order: assert property (@(posedge clk) disable iff (rst)
    !bif.interleaved && bif.step && !bif.load
    |=> bif.cur == $past(bif.cur) + BURST_ONE)
    else $error("linear step wrong");
endmodule

// File: test/pbs_master_model.sv
// bus master model that drives the memory port pins
module pbs_master_model (
  // clock and read data
  input wire logic i_clk,
  input wire logic [pbs_pkg::DATA_W-1:0] i_rd,
  // address, selects and strobes
  output logic [pbs_pkg::ADDR_W-1:0] o_a,
  output logic o_cs1_n,
  output logic o_cs2,
  output logic o_cs3_n,
  output logic o_proc_n,
  output logic o_ctrl_n,
  output logic o_step_n,
  // write controls and data
  output logic o_all_n,
  output logic o_ben_n,
  output logic [pbs_pkg::LANES-1:0] o_lanes_n,
  output logic [pbs_pkg::DATA_W-1:0] o_wd,
  // asynchronous controls and strap
  output logic o_oe_n,
  output logic o_sleep,
  output logic o_mode
);
  import pbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus: selected, no strobes, no writes
  initial begin
    {o_a, o_cs1_n, o_cs3_n, o_oe_n, o_sleep, o_wd} = '0;
    {o_cs2, o_proc_n, o_ctrl_n, o_step_n, o_all_n, o_ben_n, o_mode} = '1;
    o_lanes_n = 4'hF;
  end
  // controller strobe write, single cycle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] ln,
    input logic al, be, input logic [DATA_W-1:0] d);
    @(negedge i_clk) o_oe_n = 1;
    @(negedge i_clk) o_a = a;
    {o_ctrl_n, o_lanes_n, o_all_n, o_ben_n, o_wd} = {1'b0, ln, al, be, d};
    @(negedge i_clk) {o_ctrl_n, o_lanes_n, o_all_n, o_ben_n} = '1;
    o_wd = ~d;
    o_oe_n = 0;
  endtask
  // both strobes low with write active, then optional second-cycle write
  task automatic pwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic w);
    @(negedge i_clk) o_oe_n = 1;
    @(negedge i_clk) o_a = a;
    {o_proc_n, o_ctrl_n, o_all_n, o_wd} = {3'b000, ~d};
    @(negedge i_clk) {o_proc_n, o_ctrl_n, o_all_n, o_wd} = {2'b11, ~w, d};
    @(negedge i_clk) o_all_n = 1;
    o_wd = ~d;
    o_oe_n = 0;
  endtask
  // read start then continue or suspend, capturing each word
  task automatic rd(input logic [ADDR_W-1:0] a, input int n, input logic st,
    output logic [DATA_W-1:0] q [4]);
    repeat (2) @(negedge i_clk);
    o_a = a;
    o_ctrl_n = 0;
    @(negedge i_clk) o_ctrl_n = 1;
    o_step_n = st;
    @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk) q[i] = i_rd;
    end
    o_step_n = 1;
  endtask
  // deselect cycle, then set the sleep request level
  task automatic nap(input logic on);
    @(negedge i_clk) o_cs1_n = 1;
    o_ctrl_n = 0;
    @(negedge i_clk) o_ctrl_n = 1;
    o_sleep = on;
    if (!on) repeat (4) @(negedge i_clk);
    o_cs1_n = 0;
  endtask
endmodule

// File: test/tb_top.sv
// self-checking bench for the pipelined burst memory port
module tb_top;
  import pbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, rst = 1, o_cs1_n, o_cs2, o_cs3_n, o_proc_n, o_ctrl_n;
  logic o_step_n, o_all_n, o_ben_n, o_oe_n, o_sleep, o_mode, oe, asleep;
  logic [ADDR_W-1:0] o_a;
  logic [LANES-1:0] o_lanes_n;
  logic [DATA_W-1:0] o_wd, i_rd, q [4];
  int errors = 0, n_checks = 0;
  // free-running core clock
  always #20 i_clk = ~i_clk;
  pbs_sram_port dut (.I_CORE_CLK(i_clk), .I_SYS_RST(rst), .I_ADDR(o_a),
    .I_CHIP_SELECT_PRIMARY_N(o_cs1_n), .I_CHIP_SELECT_ACTIVE_HIGH(o_cs2),
    .I_CHIP_SELECT_SECONDARY_LOW_N(o_cs3_n),
    .I_PROCESSOR_ADDRESS_STROBE_N(o_proc_n),
    .I_CONTROLLER_ADDRESS_STROBE_N(o_ctrl_n), .I_BURST_ADVANCE_N(o_step_n),
    .I_GLOBAL_WRITE_ALL_N(o_all_n), .I_BYTE_WRITE_MASTER_ENABLE_N(o_ben_n),
    .I_BYTE_LANE_SELECT_N(o_lanes_n), .I_OUTPUT_DRIVE_ENABLE_N(o_oe_n),
    .I_SLEEP_REQUEST(o_sleep), .I_BURST_MODE(o_mode), .I_DATA_LINES(o_wd),
    .O_DATA_LINES(i_rd), .O_DATA_LINES_OE(oe), .O_ASLEEP(asleep));
  pbs_master_model m (.i_clk, .i_rd, .o_a, .o_cs1_n, .o_cs2, .o_cs3_n,
    .o_proc_n, .o_ctrl_n, .o_step_n, .o_all_n, .o_ben_n, .o_lanes_n, .o_wd,
    .o_oe_n, .o_sleep, .o_mode);
  // distinct word per address
  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {4{a[8:0] ^ 9'h15A}};
  endfunction
  // compare and count
  task automatic check(input string nm, input logic [DATA_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // burst read with expected order
  task automatic burst(input logic [ADDR_W-1:0] a, input int n,
    input logic st, lin);
    logic [1:0] lo;
    m.rd(a, n, st, q);
    for (int i = 0; i < n; i++) begin
      lo = st ? a[1:0] : (lin ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i));
      check("burst", q[i], pat({a[ADDR_W-1:2], lo}));
    end
    check("drive", 36'(oe), 36'h1);
  endtask
  // single read
  task automatic rd1(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    m.rd(a, 1, 1'b1, q);
    check("word", q[0], e);
  endtask
  // verdict and end of run
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000 errors++;
    give_verdict;
  end
  // test sequence
  initial begin
    repeat (5) @(negedge i_clk);
    rst = 0;
    repeat (3) @(negedge i_clk);
    for (int k = 4; k < 10; k++) m.wr(k, 4'hF, 1'b0, 1'b1, pat(k));
    burst(5, 4, 1'b0, 1'b0);
    burst(6, 3, 1'b1, 1'b0);
    m.o_mode = 0;
    burst(7, 4, 1'b0, 1'b1);
    m.wr(8, 4'hA, 1'b1, 1'b0, '0);
    rd1(8, pat(8) & {9'h1FF, 9'h000, 9'h1FF, 9'h000});
    m.wr(9, 4'h0, 1'b1, 1'b1, '0);
    rd1(9, pat(9));
    m.pwr(9, 36'h0, 1'b0);
    rd1(9, pat(9));
    m.pwr(4, 36'hABCDE1234, 1'b1);
    rd1(4, 36'hABCDE1234);
    m.wr(5, 4'h3, 1'b1, 1'b0, 36'h0);
    rd1(5, pat(5) & {18'h0, 18'h3FFFF});
    check("drive", 36'(oe), 36'h1);
    m.nap(1'b0);
    check("drive", 36'(oe), 36'h0);
    m.nap(1'b1);
    // two sync edges, two entry cycles, one output register stage
    repeat (SLEEP_CYCLES + 3) @(negedge i_clk);
    check("asleep", 36'(asleep), 36'h1);
    check("drive", 36'(oe), 36'h0);
    m.nap(1'b0);
    repeat (2) @(negedge i_clk);
    check("asleep", 36'(asleep), 36'h0);
    rd1(9, pat(9));
    give_verdict;
  end
endmodule
